/* hdl/e1_sync_pkg.sv */
// constants and types for the e1 sync, alarm and common control block
//
// Overview of operation
// (RL1) two successive cas multiframe words in error latch the cas resync event
// (RL2) three successive bad frame alignment words latch the resync event
// (RL3) 915 bad codewords out of 1000 latch the crc resync event
// (RL4) three live read-only search flags, high only while each search runs
// (RL5) each fruitless 8 ms crc multiframe search window bumps the counter
// (RL6) counter clears on crc multiframe sync or when crc mode is off
// (RL7) 6-bit wrapping counter; bit 0 and bits 2..5 read in bits 3..7
// (RL8) software should give up the crc search after about 400 ms
// (RL9) sync lost from reset, on any resync criterion and on manual resync
// (RL10) carrier lost after 255 or 2048 zeros; cleared by 32 ones in 255
// (RL11) remote alarm after three ones, cleared after three zeros, in bit 3
// (RL12) all-ones alarm: fewer than three zeros per 512 bits sets it
// (RL13) distant multiframe alarm after two multiframes with ts16 bit 6 set
// (RL14) link identification when two of three sa7 bits are zero
// (RL15) control bit picks sync lost or transmit clock lost for alarm pin
// (RL16) two-bit field picks pin, failover, scaled master or recovered clock
// (RL17) idle array address advances per data access unless disabled
// (RL18) mode bit gives full or half period line output pulses
// (RL19) integration reports signaling change only after three stable frames
// (RL20) recalculate bit selects intermediate path crc-4 generation
// (RL21) master clock comes from its pin or the transmit system clock pin
// (RL22) id register: fixed device code high nibble, revision low nibble
// (RL23) alternate criteria bit picks 255 or 2048 zeros for carrier loss
// (RL24) resync event flags stay set until the host reads them
// (RL25) common control register resets to all zeros
package e1_sync_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ID      = 8'h0f;
	localparam logic [7:0] ADDR_RESYNC  = 8'h12;
	localparam logic [7:0] ADDR_SEARCH  = 8'h30;
	localparam logic [7:0] ADDR_CTRL    = 8'h70;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam int CTRL_PIN_FN   = 0;
	localparam int CTRL_TCS_LO   = 1;
	localparam int CTRL_TCS_HI   = 2;
	localparam int CTRL_AUTOINC_DIS = 3;
	localparam int CTRL_ODM      = 4;
	localparam int CTRL_SIE      = 5;
	localparam int CTRL_CRC_RECALC = 6;
	localparam int CTRL_MCLK_SRC = 7;
	localparam int EV_CAS = 0;
	localparam int EV_FAS = 1;
	localparam int EV_CRC = 2;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int CRC_WINDOW_US   = 8000;
	localparam int CRC_WINDOW_CYC  = CRC_WINDOW_US
		* (1000000 / CLK_PERIOD_PS);
	localparam int CHANNEL_TIME_PS = 3906250;
	localparam int TRANSMIT_CLOCK_LOST_CYC = (CHANNEL_TIME_PS + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam int FAS_ERR_N    = 3;
	localparam int CAS_ERR_N    = 2;
	localparam int CRC_BLOCK    = 1000;
	localparam int CRC_ERR_LIM  = 915;
	localparam int ZERO_RUN_STD = 255;
	localparam int ZERO_RUN_ALT = 2048;
	localparam int ONES_CLEAR   = 32;
	localparam int ONES_WIN     = 255;
	localparam int RRA_N        = 3;
	localparam int UA1_WIN      = 512;
	localparam int UA1_ZEROS    = 3;
	localparam int DISTANT_MULTIFRAME_ALARM_N       = 2;
	localparam int SIG_STABLE_N = 3;
	localparam int CSC_W        = 6;
	typedef enum logic [1:0] {
		TXCLK_PIN, TXCLK_FAILOVER, TXCLK_MCLK, TXCLK_RCLK
	} txclk_sel_t;
endpackage

/* hdl/e1_host_if.sv */
// bundle between the host port decoder and the core
`timescale 1ns/1ps
`default_nettype none
interface e1_host_if;
	logic [7:0] ctrl;
	logic [2:0] resync_ev;
	logic [7:0] search_rt;
	logic       resync_read;
	modport port (output ctrl, output resync_read, input resync_ev,
		input search_rt);
	modport core (input ctrl, input resync_read, output resync_ev,
		output search_rt);
endinterface
`default_nettype wire

/* hdl/e1_run_counter.sv */
// counts consecutive hits among strobed samples and pulses at n
`timescale 1ns/1ps
`default_nettype none
module e1_run_counter #(
	parameter int N = 3
) (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	input  wire logic sample_i,
	input  wire logic hit_i,
	input  wire logic restart_i,
	output logic      reached_o
);
	logic [3:0] cnt_ff;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cnt_ff <= 4'h0;
		else if (restart_i || (sample_i && !hit_i) || reached_o)
			cnt_ff <= 4'h0;
		else if (sample_i)
			cnt_ff <= cnt_ff + 4'h1;
	end

	assign reached_o = sample_i && hit_i && (cnt_ff == 4'(N - 1));
endmodule // e1_run_counter
`default_nettype wire

/* hdl/e1_host_port.sv */
// parallel port decode, control register and read mux
`timescale 1ns/1ps
`default_nettype none
module e1_host_port #(
	parameter logic [3:0] DEVICE_CODE = 4'h5, // arbitrary value
	parameter logic [3:0] DIE_REV     = 4'h0
) (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_stb_i,
	input  wire logic       rd_stb_i,
	output logic      [7:0] rd_data_o,
	e1_host_if.port         hp
);
	import e1_sync_pkg::*;
	logic [7:0] ctrl_ff;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ctrl_ff <= CTRL_RESET; // [RL25]
		else if (wr_stb_i && addr_i == ADDR_CTRL)
			ctrl_ff <= wr_data_i;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rd_data_o <= 8'h00;
		else if (rd_stb_i)
			unique case (addr_i)
				ADDR_ID:     rd_data_o <= {DEVICE_CODE, DIE_REV}; // [RL22]
				ADDR_RESYNC: rd_data_o <= {5'h00, hp.resync_ev};
				ADDR_SEARCH: rd_data_o <= hp.search_rt; // [RL4]
				ADDR_CTRL:   rd_data_o <= ctrl_ff;
				default:     rd_data_o <= READ_UNMAPPED;
			endcase
	end

	assign hp.ctrl        = ctrl_ff;
	assign hp.resync_read = rd_stb_i && addr_i == ADDR_RESYNC; // [RL24]
endmodule // e1_host_port
`default_nettype wire

/* hdl/e1_sync_alarm.sv */
// e1 receive sync status, alarm detection and common control
`timescale 1ns/1ps
`default_nettype none
module e1_sync_alarm #(
	parameter int         CRC_WIN_CYC = e1_sync_pkg::CRC_WINDOW_CYC,
	parameter logic [3:0] DEVICE_CODE = 4'h5, // arbitrary value
	parameter logic [3:0] DIE_REV     = 4'h0
) (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// host parallel port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_stb_i,
	input  wire logic       rd_stb_i,
	output logic      [7:0] rd_data_o,
	// receive control bits held elsewhere
	input  wire logic       rx_crc4_enable_i,
	input  wire logic       manual_resync_i,
	input  wire logic       carrier_loss_alt_criteria_i,
	// framer word checks
	input  wire logic       fas_check_i,
	input  wire logic       fas_ok_i,
	input  wire logic       fas_sync_found_i,
	input  wire logic       cas_check_i,
	input  wire logic       cas_ok_i,
	input  wire logic       cas_sync_found_i,
	input  wire logic       crc_word_i,
	input  wire logic       crc_err_i,
	input  wire logic       crc_sync_found_i,
	// received bit stream and overhead samples
	input  wire logic       rx_bit_valid_i,
	input  wire logic       rx_bit_i,
	input  wire logic       na_bit3_valid_i,
	input  wire logic       na_bit3_i,
	input  wire logic       ts16_mf_valid_i,
	input  wire logic       ts16_bit6_i,
	input  wire logic       sa7_valid_i,
	input  wire logic       sa7_i,
	input  wire logic       sig_mf_i,
	input  wire logic [3:0] sig_value_i,
	// clocks and line data, sampled
	input  wire logic       transmit_clock_pin_i,
	input  wire logic       recovered_clock_i,
	input  wire logic       scaled_master_clock_i,
	input  wire logic       master_clock_pin_i,
	input  wire logic       transmit_system_clock_pin_i,
	input  wire logic       transmit_output_clock_i,
	input  wire logic       tx_pos_data_i,
	input  wire logic       tx_neg_data_i,
	input  wire logic       idle_code_data_access_i,
	// status and control outputs
	output logic            receive_sync_lost_o,
	output logic            receive_carrier_lost_o,
	output logic            remote_alarm_seen_o,
	output logic            unframed_ones_seen_o,
	output logic            distant_multiframe_alarm_o,
	output logic            link_ident_detected_o,
	output logic            transmit_clock_lost_o,
	output logic            alarm_pin_o,
	output logic            tx_clock_o,
	output logic            master_clock_o,
	output logic            line_out_positive_o,
	output logic            line_out_negative_o,
	output logic            idle_addr_advance_o,
	output logic            sig_change_o,
	output logic      [3:0] sig_state_o,
	output logic            crc_recalculate_o
);
	import e1_sync_pkg::*;

	e1_host_if hp ();

	e1_host_port #(.DEVICE_CODE(DEVICE_CODE), .DIE_REV(DIE_REV)) u_port (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.addr_i    (addr_i),
		.wr_data_i (wr_data_i),
		.wr_stb_i  (wr_stb_i),
		.rd_stb_i  (rd_stb_i),
		.rd_data_o (rd_data_o),
		.hp        (hp.port)
	);

	// ----------------------------------------------------------------
	// resync criteria
	// ----------------------------------------------------------------
	logic       fas_resync;
	logic       cas_resync;
	logic       crc_resync;
	logic [9:0] crc_words_ff;
	logic [9:0] crc_errs_ff;
	logic [2:0] resync_ev_ff;

	e1_run_counter #(.N(FAS_ERR_N)) u_fas_err (
		.mclk_i (mclk_i), .sys_rst_i (sys_rst_i),
		.sample_i (fas_check_i), .hit_i (!fas_ok_i),
		.restart_i (1'b0), .reached_o (fas_resync) // [RL2]
	);

	e1_run_counter #(.N(CAS_ERR_N)) u_cas_err (
		.mclk_i (mclk_i), .sys_rst_i (sys_rst_i),
		.sample_i (cas_check_i), .hit_i (!cas_ok_i),
		.restart_i (1'b0), .reached_o (cas_resync) // [RL1]
	);

	// errors counted per block of 1000 codewords
	assign crc_resync = crc_word_i && crc_err_i
		&& crc_errs_ff == 10'(CRC_ERR_LIM - 1); // [RL3]

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			crc_words_ff <= 10'h000;
			crc_errs_ff  <= 10'h000;
		end
		else if (crc_word_i)
		begin
			if (crc_words_ff == 10'(CRC_BLOCK - 1) || crc_resync)
			begin
				crc_words_ff <= 10'h000;
				crc_errs_ff  <= 10'h000;
			end
			else
			begin
				crc_words_ff <= crc_words_ff + 10'h001;
				crc_errs_ff  <= crc_errs_ff + {9'h000, crc_err_i};
			end
		end
	end

	// set wins over the clear-on-read
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			resync_ev_ff <= 3'h0;
		else
			resync_ev_ff <= (hp.resync_read ? 3'h0 : resync_ev_ff)
				| {crc_resync, fas_resync, cas_resync}; // [RL24]
	end

	// ----------------------------------------------------------------
	// search flags, sync lost and crc search counter
	// ----------------------------------------------------------------
	logic                 fas_search_ff;
	logic                 cas_search_ff;
	logic                 crc_search_ff;
	logic [31:0]          crc_win_ff;
	logic [CSC_W-1:0]     csc_ff;
	logic                 crc_win_done;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			fas_search_ff <= 1'b1;
			cas_search_ff <= 1'b1;
			crc_search_ff <= 1'b1;
		end
		else
		begin
			// [RL4]
			fas_search_ff <= fas_resync || manual_resync_i
				|| (fas_search_ff && !fas_sync_found_i);
			cas_search_ff <= cas_resync || manual_resync_i
				|| (cas_search_ff && !cas_sync_found_i);
			crc_search_ff <= rx_crc4_enable_i && (crc_resync
				|| manual_resync_i || (crc_search_ff && !crc_sync_found_i));
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			receive_sync_lost_o <= 1'b1; // [RL9]
		else if (fas_resync || cas_resync || crc_resync || manual_resync_i)
			receive_sync_lost_o <= 1'b1; // [RL9]
		else if (fas_sync_found_i)
			receive_sync_lost_o <= 1'b0;
	end

	assign crc_win_done = crc_search_ff
		&& crc_win_ff == 32'(CRC_WIN_CYC - 1);

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			crc_win_ff <= 32'h0;
		else if (!crc_search_ff || crc_win_done)
			crc_win_ff <= 32'h0;
		else
			crc_win_ff <= crc_win_ff + 32'h1;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			csc_ff <= '0;
		else if (crc_sync_found_i || !rx_crc4_enable_i)
			csc_ff <= '0; // [RL6]
		else if (crc_win_done)
			csc_ff <= csc_ff + 6'h01; // [RL5] [RL7]
	end

	assign hp.resync_ev = resync_ev_ff;
	assign hp.search_rt = {csc_ff[5:2], csc_ff[0], fas_search_ff,
		cas_search_ff, crc_search_ff}; // [RL7] [RL4]

	// ----------------------------------------------------------------
	// carrier loss and unframed all ones
	// ----------------------------------------------------------------
	logic [11:0] zero_run_ff;
	logic [7:0]  ones_win_ff;
	logic [5:0]  ones_cnt_ff;
	logic [8:0]  ua1_win_ff;
	logic [1:0]  ua1_zeros_ff;
	logic [11:0] zero_limit;

	assign zero_limit = carrier_loss_alt_criteria_i ? 12'(ZERO_RUN_ALT)
		: 12'(ZERO_RUN_STD); // [RL23]

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			zero_run_ff <= 12'h000;
		else if (rx_bit_valid_i)
			zero_run_ff <= rx_bit_i ? 12'h000
				: (zero_run_ff == zero_limit ? zero_run_ff
				: zero_run_ff + 12'h001);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ones_win_ff <= 8'h00;
			ones_cnt_ff <= 6'h00;
		end
		else if (!receive_carrier_lost_o
			|| (rx_bit_valid_i && ones_win_ff == 8'(ONES_WIN - 1)))
		begin
			ones_win_ff <= 8'h00;
			ones_cnt_ff <= 6'h00;
		end
		else if (rx_bit_valid_i)
		begin
			ones_win_ff <= ones_win_ff + 8'h01;
			ones_cnt_ff <= ones_cnt_ff + {5'h00, rx_bit_i};
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			receive_carrier_lost_o <= 1'b0;
		else if (rx_bit_valid_i && !rx_bit_i
			&& zero_run_ff == zero_limit - 12'h001)
			receive_carrier_lost_o <= 1'b1; // [RL10]
		else if (rx_bit_valid_i && rx_bit_i
			&& ones_cnt_ff == 6'(ONES_CLEAR - 1))
			receive_carrier_lost_o <= 1'b0; // [RL10]
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ua1_win_ff           <= 9'h000;
			ua1_zeros_ff         <= 2'h0;
			unframed_ones_seen_o <= 1'b0;
		end
		else if (rx_bit_valid_i)
		begin
			ua1_win_ff <= ua1_win_ff + 9'h001;
			if (ua1_win_ff == 9'(UA1_WIN - 1))
			begin
				ua1_zeros_ff <= 2'h0;
				// [RL12]
				unframed_ones_seen_o <= ({1'b0, ua1_zeros_ff}
					+ {2'h0, !rx_bit_i}) < 3'(UA1_ZEROS);
			end
			else if (!rx_bit_i && ua1_zeros_ff != 2'(UA1_ZEROS))
				ua1_zeros_ff <= ua1_zeros_ff + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// remote alarm, distant multiframe alarm, link identification
	// ----------------------------------------------------------------
	logic rra_set;
	logic rra_clr;
	logic distant_multiframe_alarm_set;
	logic [2:0] sa7_hist_ff;

	e1_run_counter #(.N(RRA_N)) u_rra_set (
		.mclk_i (mclk_i), .sys_rst_i (sys_rst_i),
		.sample_i (na_bit3_valid_i), .hit_i (na_bit3_i),
		.restart_i (1'b0), .reached_o (rra_set)
	);

	e1_run_counter #(.N(RRA_N)) u_rra_clr (
		.mclk_i (mclk_i), .sys_rst_i (sys_rst_i),
		.sample_i (na_bit3_valid_i), .hit_i (!na_bit3_i),
		.restart_i (1'b0), .reached_o (rra_clr)
	);

	e1_run_counter #(.N(DISTANT_MULTIFRAME_ALARM_N)) u_distant_multiframe_alarm (
		.mclk_i (mclk_i), .sys_rst_i (sys_rst_i),
		.sample_i (ts16_mf_valid_i), .hit_i (ts16_bit6_i),
		.restart_i (1'b0), .reached_o (distant_multiframe_alarm_set)
	);

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			remote_alarm_seen_o        <= 1'b0;
			distant_multiframe_alarm_o <= 1'b0;
		end
		else
		begin
			if (rra_set)
				remote_alarm_seen_o <= 1'b1; // [RL11]
			else if (rra_clr)
				remote_alarm_seen_o <= 1'b0; // [RL11]
			if (distant_multiframe_alarm_set)
				distant_multiframe_alarm_o <= 1'b1; // [RL13]
			else if (ts16_mf_valid_i && !ts16_bit6_i)
				distant_multiframe_alarm_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sa7_hist_ff <= 3'h7;
		else if (sa7_valid_i)
			sa7_hist_ff <= {sa7_hist_ff[1:0], sa7_i};
	end

	// two or more zeros among the last three samples
	assign link_ident_detected_o = (!sa7_hist_ff[0] && !sa7_hist_ff[1])
		|| (!sa7_hist_ff[0] && !sa7_hist_ff[2])
		|| (!sa7_hist_ff[1] && !sa7_hist_ff[2]); // [RL14]

	// ----------------------------------------------------------------
	// signaling change reporting
	// ----------------------------------------------------------------
	logic [3:0] sig_last_ff;
	logic [1:0] sig_stable_ff;
	logic       sig_ready;

	assign sig_ready = hp.ctrl[CTRL_SIE]
		? (sig_value_i == sig_last_ff
			&& sig_stable_ff == 2'(SIG_STABLE_N - 2)) // [RL19]
		: 1'b1; // [RL19]

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sig_last_ff   <= 4'h0;
			sig_stable_ff <= 2'h0;
			sig_state_o   <= 4'h0;
			sig_change_o  <= 1'b0;
		end
		else
		begin
			sig_change_o <= 1'b0;
			if (sig_mf_i)
			begin
				sig_last_ff   <= sig_value_i;
				sig_stable_ff <= sig_value_i != sig_last_ff ? 2'h0
					: (sig_stable_ff == 2'h3 ? 2'h3 : sig_stable_ff + 2'h1);
				if (sig_ready && sig_value_i != sig_state_o)
				begin
					sig_state_o  <= sig_value_i;
					sig_change_o <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// common control: clocks, alarm pin, line pulses
	// ----------------------------------------------------------------
	logic        transmit_clock_pin_prev_ff;
	logic [9:0]  transmit_clock_pin_idle_ff;
	txclk_sel_t  tx_sel;

	assign tx_sel = txclk_sel_t'({hp.ctrl[CTRL_TCS_HI], hp.ctrl[CTRL_TCS_LO]});

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			transmit_clock_pin_prev_ff <= 1'b0;
			transmit_clock_pin_idle_ff <= 10'h000;
		end
		else
		begin
			transmit_clock_pin_prev_ff <= transmit_clock_pin_i;
			if (transmit_clock_pin_i != transmit_clock_pin_prev_ff)
				transmit_clock_pin_idle_ff <= 10'h000;
			else if (transmit_clock_pin_idle_ff != 10'(TRANSMIT_CLOCK_LOST_CYC))
				transmit_clock_pin_idle_ff <= transmit_clock_pin_idle_ff + 10'h001;
		end
	end

	assign transmit_clock_lost_o = transmit_clock_pin_idle_ff == 10'(TRANSMIT_CLOCK_LOST_CYC);

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			tx_clock_o          <= 1'b0;
			master_clock_o      <= 1'b0;
			alarm_pin_o         <= 1'b1;
			line_out_positive_o <= 1'b0;
			line_out_negative_o <= 1'b0;
		end
		else
		begin
			unique case (tx_sel) // [RL16]
				TXCLK_PIN:      tx_clock_o <= transmit_clock_pin_i;
				TXCLK_FAILOVER: tx_clock_o <= transmit_clock_lost_o
					? recovered_clock_i : transmit_clock_pin_i;
				TXCLK_MCLK:     tx_clock_o <= scaled_master_clock_i;
				TXCLK_RCLK:     tx_clock_o <= recovered_clock_i;
			endcase
			master_clock_o <= hp.ctrl[CTRL_MCLK_SRC]
				? transmit_system_clock_pin_i : master_clock_pin_i; // [RL21]
			alarm_pin_o <= hp.ctrl[CTRL_PIN_FN]
				? transmit_clock_lost_o : receive_sync_lost_o; // [RL15]
			// half width pulses only in the clock high half
			line_out_positive_o <= tx_pos_data_i
				&& (!hp.ctrl[CTRL_ODM] || transmit_output_clock_i); // [RL18]
			line_out_negative_o <= tx_neg_data_i
				&& (!hp.ctrl[CTRL_ODM] || transmit_output_clock_i); // [RL18]
		end
	end

	assign idle_addr_advance_o = idle_code_data_access_i
		&& !hp.ctrl[CTRL_AUTOINC_DIS]; // [RL17]
	assign crc_recalculate_o = hp.ctrl[CTRL_CRC_RECALC]; // [RL20]
endmodule // e1_sync_alarm
`default_nettype wire

/* verif/e1_sync_properties.sv */
// concurrent checks on the sync and alarm block ports
`timescale 1ns/1ps
`default_nettype none
module e1_sync_properties (
	input wire logic       mclk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_stb_i,
	input wire logic       manual_resync_i,
	input wire logic       fas_check_i,
	input wire logic       fas_ok_i,
	input wire logic       cas_check_i,
	input wire logic       cas_ok_i,
	input wire logic       na_bit3_valid_i,
	input wire logic       na_bit3_i,
	input wire logic       ts16_mf_valid_i,
	input wire logic       ts16_bit6_i,
	input wire logic       sa7_valid_i,
	input wire logic       sa7_i,
	input wire logic       receive_sync_lost_o,
	input wire logic       remote_alarm_seen_o,
	input wire logic       distant_multiframe_alarm_o,
	input wire logic       link_ident_detected_o,
	input wire logic       crc_recalculate_o
);
	import e1_sync_pkg::*;
	// --------
	// port relations
	// --------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence fas_bad;
		fas_check_i && !fas_ok_i;
	endsequence
	AST_FAS_RESYNC:
		assert property (fas_bad [*3] |=> receive_sync_lost_o)
		else $error("no sync loss after bad fas");
	AST_CAS_RESYNC:
		assert property ((cas_check_i && !cas_ok_i) [*2]
			|=> receive_sync_lost_o) else $error("no sync loss after cas");
	AST_MANUAL_RESYNC:
		assert property (manual_resync_i |=> receive_sync_lost_o)
		else $error("no sync loss after manual resync");
	AST_REMOTE_SET:
		assert property ((na_bit3_valid_i && na_bit3_i) [*3]
			|=> remote_alarm_seen_o) else $error("remote alarm not set");
	AST_REMOTE_CLEAR:
		assert property ((na_bit3_valid_i && !na_bit3_i) [*3]
			|=> !remote_alarm_seen_o) else $error("remote alarm stuck");
	AST_DISTANT_MF:
		assert property ((ts16_mf_valid_i && ts16_bit6_i) [*2]
			|=> distant_multiframe_alarm_o) else $error("no distant alarm");
	AST_LINK_IDENT:
		assert property ((sa7_valid_i && !sa7_i) [*2]
			|=> link_ident_detected_o) else $error("no link ident");
	AST_RECALC:
		assert property (wr_stb_i && addr_i == ADDR_CTRL
			|=> crc_recalculate_o == $past(wr_data_i[CTRL_CRC_RECALC]))
		else $error("recalculate bit not applied");
endmodule // e1_sync_properties
`default_nettype wire

/* verif/e1_line_model.sv */
// line side source of received e1 bits
`timescale 1ns/1ps
`default_nettype none
module e1_line_model (
	input  wire logic       mclk_i,
	input  wire logic [1:0] pat_i,
	output var  logic       rx_bit_valid_o = 1'h0,
	output var  logic       rx_bit_o = 1'h0
);
	logic [1:0] cur;
	logic [6:0] pos_ff = 7'h00;
	// --------
	// bit stream
	// --------
	// pattern 0 idle, 1 zeros, 2 ones, 3 ones with a zero per 128 bits
	always @(posedge mclk_i)
	begin
		cur = pat_i;
		#1;
		pos_ff = pos_ff + 7'h01;
		rx_bit_valid_o = (cur != 2'h0);
		if (cur == 2'h0)
			rx_bit_o = !rx_bit_o; // idle line holds no value
		else
			rx_bit_o = cur[1] && !(cur[0] && pos_ff == 7'h00);
	end
endmodule // e1_line_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the e1 sync, alarm and control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import e1_sync_pkg::*;
	logic mclk_i = 1'h0, sys_rst_i = 1'h1, wr_stb_i = 1'h0, rd_stb_i = 1'h0;
	logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, cv;
	logic [3:0] sig_value_i = 4'h0, sig_state_o;
	logic [1:0] pat = 2'h0;
	logic rx_crc4_enable_i = 1'h1, manual_resync_i = 1'h0, fas_ok_i = 1'h0;
	logic carrier_loss_alt_criteria_i = 1'h0, fas_check_i = 1'h0;
	logic fas_sync_found_i = 1'h0, cas_check_i = 1'h0, cas_ok_i = 1'h0;
	logic cas_sync_found_i = 1'h0, crc_word_i = 1'h0, crc_err_i = 1'h0;
	logic crc_sync_found_i = 1'h0, na_bit3_valid_i = 1'h0, sa7_i = 1'h0;
	logic na_bit3_i = 1'h0, ts16_mf_valid_i = 1'h0, ts16_bit6_i = 1'h0;
	logic sa7_valid_i = 1'h0, sig_mf_i = 1'h0, transmit_clock_pin_i = 1'h0;
	logic recovered_clock_i = 1'h0, scaled_master_clock_i = 1'h0;
	logic master_clock_pin_i = 1'h0, transmit_system_clock_pin_i = 1'h0;
	logic transmit_output_clock_i = 1'h0, tx_pos_data_i = 1'h0;
	logic tx_neg_data_i = 1'h0, idle_code_data_access_i = 1'h0;
	logic rx_bit_valid_i, rx_bit_i, receive_sync_lost_o, tx_clock_o;
	logic receive_carrier_lost_o, remote_alarm_seen_o, unframed_ones_seen_o;
	logic distant_multiframe_alarm_o, link_ident_detected_o, sig_change_o;
	logic transmit_clock_lost_o, alarm_pin_o, master_clock_o;
	logic line_out_positive_o, line_out_negative_o, idle_addr_advance_o;
	logic crc_recalculate_o;
	int failures = 0, samples_checked = 0;
	// --------
	// harness and access tasks
	// --------
	always #2 mclk_i = !mclk_i;
	e1_sync_alarm #(.CRC_WIN_CYC(20)) dut_u (.*);
	e1_line_model line_u (.mclk_i(mclk_i), .pat_i(pat),
		.rx_bit_valid_o(rx_bit_valid_i), .rx_bit_o(rx_bit_i));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, m, e);
		addr_i = a;
		rd_stb_i = 1'h1;
		tick(1);
		rd_stb_i = 1'h0;
		chk($sformatf("reg %h", a), e, rd_data_o & m);
		tick(1);
	endtask
	task automatic wr(input logic [7:0] a, d);
		{addr_i, wr_data_i, wr_stb_i} = {a, d, 1'h1};
		tick(1);
		wr_stb_i = 1'h0;
		tick(1);
	endtask
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		tick(20000);
		failures++;
		wrap_up();
	end
	initial
	begin
		tick(8);
		sys_rst_i = 1'h0;
		chk("lost", 8'h01, 8'(receive_sync_lost_o));
		rdc(ADDR_ID, 8'hff, 8'h50);
		rdc(ADDR_CTRL, 8'hff, CTRL_RESET);
		rdc(ADDR_SEARCH, 8'hff, 8'h07);
		rdc(8'h55, 8'hff, READ_UNMAPPED);
		{fas_sync_found_i, cas_sync_found_i, crc_sync_found_i} = 3'h7;
		tick(1);
		{fas_sync_found_i, cas_sync_found_i, crc_sync_found_i} = 3'h0;
		rdc(ADDR_SEARCH, 8'hff, 8'h00);
		chk("lost", 8'h00, 8'(receive_sync_lost_o));
		fas_check_i = 1'h1;
		tick(3);
		fas_check_i = 1'h0;
		rdc(ADDR_RESYNC, 8'hff, 8'h02);
		rdc(ADDR_RESYNC, 8'hff, 8'h00);
		rdc(ADDR_SEARCH, 8'h04, 8'h04);
		cas_check_i = 1'h1;
		tick(2);
		cas_check_i = 1'h0;
		rdc(ADDR_RESYNC, 8'hff, 8'h01);
		crc_word_i = 1'h1;
		tick(85);
		crc_err_i = 1'h1;
		tick(914);
		crc_word_i = 1'h0;
		rdc(ADDR_RESYNC, 8'hff, 8'h00);
		crc_word_i = 1'h1;
		tick(1);
		{crc_word_i, crc_err_i, crc_sync_found_i} = 3'h1;
		rdc(ADDR_RESYNC, 8'hff, 8'h04);
		{crc_sync_found_i, manual_resync_i} = 2'h1;
		tick(1);
		manual_resync_i = 1'h0;
		tick(70);
		rdc(ADDR_SEARCH, 8'hf8, 8'h08);
		tick(60);
		rdc(ADDR_SEARCH, 8'hf8, 8'h10);
		rx_crc4_enable_i = 1'h0; // abandon the long crc search
		tick(2);
		rdc(ADDR_SEARCH, 8'hf9, 8'h00);
		{rx_crc4_enable_i, pat} = 3'h5;
		tick(250);
		chk("carrier", 8'h00, 8'(receive_carrier_lost_o));
		tick(10);
		chk("carrier", 8'h01, 8'(receive_carrier_lost_o));
		pat = 2'h2;
		tick(40);
		chk("carrier", 8'h00, 8'(receive_carrier_lost_o));
		{carrier_loss_alt_criteria_i, pat} = 3'h5;
		tick(1000);
		chk("carrier", 8'h00, 8'(receive_carrier_lost_o));
		tick(1100);
		chk("carrier", 8'h01, 8'(receive_carrier_lost_o));
		pat = 2'h2;
		tick(1100);
		chk("ones", 8'h01, 8'(unframed_ones_seen_o));
		pat = 2'h3;
		tick(1100);
		chk("ones", 8'h00, 8'(unframed_ones_seen_o));
		{na_bit3_valid_i, na_bit3_i} = 2'h3;
		tick(3);
		na_bit3_i = 1'h0;
		tick(3);
		{na_bit3_valid_i, ts16_mf_valid_i, ts16_bit6_i} = 3'h3;
		tick(2);
		{ts16_mf_valid_i, sa7_valid_i, fas_sync_found_i} = 3'h3;
		tick(2);
		{sa7_valid_i, fas_sync_found_i} = 2'h0;
		chk("alarm", 8'h03, 8'({remote_alarm_seen_o,
			distant_multiframe_alarm_o, link_ident_detected_o}));
		for (int i = 0; i < 4; i++)
		begin
			transmit_clock_pin_i = (i < 2);
			scaled_master_clock_i = (i == 2);
			recovered_clock_i = (i == 3);
			transmit_system_clock_pin_i = i[0];
			cv = {i[0], 4'h0, i[1:0], 1'h0};
			wr(ADDR_CTRL, cv);
			rdc(ADDR_CTRL, 8'hff, cv);
			chk("txclk", 8'h01, 8'(tx_clock_o));
			chk("mclk", 8'(i[0]), 8'(master_clock_o));
			chk("pin", 8'h00, 8'(alarm_pin_o));
		end
		{transmit_clock_pin_i, recovered_clock_i} = 2'h1;
		wr(ADDR_CTRL, 8'h03);
		chk("txclk", 8'h00, 8'(tx_clock_o));
		tick(990);
		chk("txclk", 8'h01, 8'(tx_clock_o));
		chk("pin", 8'h01, 8'(alarm_pin_o));
		{tx_pos_data_i, idle_code_data_access_i} = 2'h3;
		wr(ADDR_CTRL, 8'h50);
		chk("out", 8'h00, 8'(line_out_positive_o));
		chk("idle", 8'h01, 8'(idle_addr_advance_o));
		wr(ADDR_CTRL, 8'h08);
		chk("out", 8'h01, 8'(line_out_positive_o));
		chk("idle", 8'h00, 8'(idle_addr_advance_o));
		{sig_value_i, sig_mf_i} = 5'h0b;
		tick(1);
		chk("sig", 8'h15, 8'({sig_change_o, sig_state_o}));
		wrap_up();
	end
endmodule // tb
bind e1_sync_alarm e1_sync_properties chk_u (.*);
`default_nettype wire
